/* hw/cis_pkg.sv */
/*
 package for the core instruction subset executor: opcodes, field positions,
 phase and cycle constants, carrier structs.
 assumes an 8-bit core with 16-bit instruction words and byte program addresses.
*/
package cis_pkg;

	// opcode prefixes and fixed encodings
	localparam logic [6:0]  OP_CMP_LT_PFX   = 7'h30;   // 0110 000
	localparam logic [5:0]  OP_SWAP_PFX     = 6'h0e;   // 0011 10
	localparam logic [4:0]  OP_RELATIVE_SUBROUTINE_CALL_PFX    = 5'h1b;   // 1101 1
	localparam logic [15:0] OP_DAW          = 16'h0007;
	localparam logic [15:0] OP_SWRESET      = 16'h00ff;
	// field positions in the instruction word
	localparam int          BIT_ACCESS      = 8;
	localparam int          BIT_DEST        = 9;
	localparam int          OFS_WIDTH       = 11;
	// indexed literal offset window
	localparam logic [7:0]  ILO_LIMIT       = 8'h5f;
	// access bank split: first 0x60 bytes of access bank in bank 0, upper part in bank f
	localparam logic [7:0]  ACC_SPLIT       = 8'h60;
	localparam logic [3:0]  ACC_HI_BANK     = 4'hf;
	// bcd adjust constants
	localparam logic [3:0]  BCD_MAX_DIGIT   = 4'h9;
	localparam logic [3:0]  BCD_FIX         = 4'h6;
	// phases per instruction cycle and program counter step
	localparam logic [1:0]  PHASE_LAST      = 2'h3;
	localparam logic [1:0]  PHASE_RESET     = 2'h1;
	localparam logic [20:0] PC_STEP         = 21'h000002;
	// reset values
	localparam logic [20:0] PC_RST          = 21'h000000;
	localparam logic [7:0]  W_RST           = 8'h00;

	// operation selected by the decoder
	typedef enum logic [2:0] {
		OPK_NONE,
		OPK_CMP_LT,
		OPK_SWAP,
		OPK_RELATIVE_SUBROUTINE_CALL,
		OPK_DAW,
		OPK_SWRESET
	} cis_op_e;

	// decoded instruction carrier
	typedef struct packed {
		cis_op_e     op;       // operation kind
		logic        acc;      // access select bit
		logic        dst;      // destination bit
		logic [7:0]  fadr;     // file operand
		logic [10:0] ofs;      // signed word offset
	} cis_dec_s;

	// data memory request carrier
	typedef struct packed {
		logic        rd;       // read strobe
		logic        wr;       // write strobe
		logic [11:0] addr;     // full data address
		logic [7:0]  wdata;    // write data
	} cis_mem_s;

	// stack push carrier
	typedef struct packed {
		logic        push;     // push strobe
		logic [20:0] data;     // return address
	} cis_stk_s;

endpackage : cis_pkg

/* hw/cis_decode.sv */
/*
 pure combinational decoder for the instruction subset.
 assumes a stable 16-bit instruction word from the fetch path.
*/
`timescale 1ns/1ps
module cis_decode (
	// instruction in
	input  wire logic [15:0]     i_instr,
	// decoded fields out
	output cis_pkg::cis_dec_s    o_dec
);

	// match prefixes and pull out fields
	always_comb
	begin
		o_dec      = '0;
		o_dec.acc  = i_instr[cis_pkg::BIT_ACCESS];
		o_dec.dst  = i_instr[cis_pkg::BIT_DEST];
		o_dec.fadr = i_instr[7:0];
		o_dec.ofs  = i_instr[cis_pkg::OFS_WIDTH-1:0];
		if (i_instr[15:9] == cis_pkg::OP_CMP_LT_PFX)
			o_dec.op = cis_pkg::OPK_CMP_LT;
		else if (i_instr[15:10] == cis_pkg::OP_SWAP_PFX)
			o_dec.op = cis_pkg::OPK_SWAP;
		else if (i_instr[15:11] == cis_pkg::OP_RELATIVE_SUBROUTINE_CALL_PFX)
			o_dec.op = cis_pkg::OPK_RELATIVE_SUBROUTINE_CALL;
		else if (i_instr == cis_pkg::OP_DAW)
			o_dec.op = cis_pkg::OPK_DAW;
		else if (i_instr == cis_pkg::OP_SWRESET)
			o_dec.op = cis_pkg::OPK_SWRESET;
		else
			o_dec.op = cis_pkg::OPK_NONE;
	end

endmodule : cis_decode

/* hw/cis_core.sv */
/*
 executes compare-skip-if-less, nibble swap, relative call, software reset
 and decimal adjust for an 8-bit core with four phases per instruction cycle.
 assumes the fetch path offers one word per cycle plus a flag telling whether
 the prefetched next word is the first of a two-word instruction; data memory
 answers reads combinationally in the same phase.
*/
// How it works
// RL1 - compare is unsigned subtraction, flags untouched
// RL2 - file below accumulator: discard next, two cycles
// RL3 - skipped two-word instruction: two idle cycles
// RL4 - access bit zero: access bank, else bank
// RL5 - swap exchanges nibbles, one cycle, no flags
// RL6 - destination zero to accumulator, one to file
// RL7 - extended set, access zero, low: indexed
// RL8 - call offset eleven-bit signed after prefix
// RL9 - call pushes counter plus two to stack
// RL10 - counter gets incremented plus twice offset
// RL11 - software reset starts clear in phase two
// RL12 - decimal adjust adds six per nibble
`timescale 1ns/1ps
module cis_core (
	// clock and reset
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst,
	input  wire logic                i_ce,
	// fetch path
	input  wire logic [15:0]         i_instr,
	input  wire logic                i_instr_valid,
	input  wire logic                i_next_two_word,
	// configuration and addressing state
	input  wire logic                i_ext_set_en,
	input  wire logic [3:0]          i_bank_select_register,
	input  wire logic [11:0]         i_index_base,
	// data memory read data
	input  wire logic [7:0]          i_mem_rdata,
	// flags in from the status register
	input  wire logic                i_carry,
	input  wire logic                i_digit_carry_flag,
	// program counter and fetch control
	output logic      [20:0]         o_pc,
	output logic                     o_flush,
	output logic                     o_stall,
	// data memory and stack
	output cis_pkg::cis_mem_s        o_mem,
	output cis_pkg::cis_stk_s        o_stk,
	// accumulator and flag updates
	output logic      [7:0]          o_wreg,
	output logic                     o_carry_we,
	output logic                     o_carry,
	// software reset request
	output logic                     o_master_clear_reset,
	// current phase
	output logic      [1:0]          o_phase
);

	// complete register state of the block
	typedef struct packed {
		logic [1:0]  phase;      // q phase 0..3
		logic [1:0]  idle;       // idle cycles still owed
		logic [20:0] pc;         // program counter
		logic [7:0]  w;          // accumulator
		logic        cwe;        // carry write pulse
		logic        cval;       // carry value
		logic        swrst;      // software reset pulse
		logic        flush;      // prefetch discard pulse
		logic [7:0]  rdat;       // operand latched at the read phase
	} cis_state_s;

	cis_state_s        st_ff;     // registered state
	cis_state_s        nxt_st;    // next state
	cis_pkg::cis_dec_s dec;       // decoded instruction
	logic [11:0]       fa;        // effective file address
	logic [7:0]        swp;       // swapped byte
	logic [8:0]        daw_lo;    // adjusted low nibble with carry
	logic [8:0]        daw_hi;    // adjusted full result with carry
	logic [20:0]       ofs_ext;   // sign extended doubled offset
	logic              run;       // instruction executes this cycle

	// instruction decoder
	cis_decode u_dec (
		.i_instr (i_instr),
		.o_dec   (dec)
	);

	assign run = i_instr_valid && (st_ff.idle == 2'h0);

	// effective data address
	always_comb
	begin
		// RL7 indexed literal offset
		if (i_ext_set_en && !dec.acc && (dec.fadr <= cis_pkg::ILO_LIMIT))
			fa = i_index_base + {4'h0, dec.fadr};
		// RL4 access bank select
		else if (!dec.acc)
			fa = (dec.fadr < cis_pkg::ACC_SPLIT) ? {4'h0, dec.fadr} : {cis_pkg::ACC_HI_BANK, dec.fadr};
		else
			fa = {i_bank_select_register, dec.fadr};
	end

	// arithmetic helpers
	always_comb
	begin
		// RL5 nibble exchange
		swp     = {st_ff.rdat[3:0], st_ff.rdat[7:4]};
		// RL8 signed offset doubled
		ofs_ext = {{9{dec.ofs[10]}}, dec.ofs, 1'b0};
		// RL12 low digit adjust
		if ((st_ff.w[3:0] > cis_pkg::BCD_MAX_DIGIT) || i_digit_carry_flag)
			daw_lo = {1'b0, st_ff.w} + {5'h00, cis_pkg::BCD_FIX};
		else
			daw_lo = {1'b0, st_ff.w};
		// RL12 high digit adjust
		if ((daw_lo[7:4] > cis_pkg::BCD_MAX_DIGIT) || i_carry || daw_lo[8])
			daw_hi = {1'b0, daw_lo[7:0]} + {1'b0, cis_pkg::BCD_FIX, 4'h0};
		else
			daw_hi = {1'b0, daw_lo[7:0]};
	end

	// next state and data memory requests
	always_comb
	begin
		nxt_st       = st_ff;
		nxt_st.cwe   = 1'b0;
		nxt_st.swrst = 1'b0;
		nxt_st.flush = 1'b0;
		o_mem        = '0;
		o_stk        = '0;
		o_mem.addr   = fa;
		nxt_st.phase = st_ff.phase + 2'h1;
		if (st_ff.phase == cis_pkg::PHASE_LAST)
		begin
			// end of an instruction cycle
			if (st_ff.idle != 2'h0)
				nxt_st.idle = st_ff.idle - 2'h1;
			else if (i_instr_valid)
				nxt_st.pc = st_ff.pc + cis_pkg::PC_STEP;
		end
		if (run)
		begin
			unique case (dec.op)
				cis_pkg::OPK_CMP_LT:
				begin
					o_mem.rd = (st_ff.phase == 2'h1);
					// RL1 unsigned compare, flags kept
					// RL2 discard next on less
					if ((st_ff.phase == cis_pkg::PHASE_LAST) && (st_ff.rdat < st_ff.w))
					begin
						nxt_st.flush = 1'b1;
						// RL3 two idle for two-word
						nxt_st.idle  = i_next_two_word ? 2'h2 : 2'h1;
						nxt_st.pc    = st_ff.pc + cis_pkg::PC_STEP + (i_next_two_word ? 21'h4 : 21'h2);
					end
				end
				cis_pkg::OPK_SWAP:
				begin
					o_mem.rd = (st_ff.phase == 2'h1);
					// RL6 destination select
					if (st_ff.phase == cis_pkg::PHASE_LAST)
					begin
						if (dec.dst)
						begin
							o_mem.wr    = 1'b1;
							o_mem.wdata = swp;
						end
						else
							nxt_st.w = swp;
					end
				end
				cis_pkg::OPK_RELATIVE_SUBROUTINE_CALL:
				begin
					// RL9 push return address
					if (st_ff.phase == 2'h1)
					begin
						o_stk.push = 1'b1;
						o_stk.data = st_ff.pc + cis_pkg::PC_STEP;
					end
					// RL10 relative jump, idle cycle
					if (st_ff.phase == cis_pkg::PHASE_LAST)
					begin
						nxt_st.pc    = st_ff.pc + cis_pkg::PC_STEP + ofs_ext;
						nxt_st.flush = 1'b1;
						nxt_st.idle  = 2'h1;
					end
				end
				cis_pkg::OPK_DAW:
				begin
					// RL12 write adjusted accumulator and carry
					if (st_ff.phase == cis_pkg::PHASE_LAST)
					begin
						nxt_st.w    = daw_hi[7:0];
						nxt_st.cwe  = 1'b1;
						// a carry out of the low-digit fix must not be lost
						nxt_st.cval = daw_hi[8] || daw_lo[8] || i_carry;
					end
				end
				cis_pkg::OPK_SWRESET:
				begin
					// RL11 reset started in second phase
					if (st_ff.phase == cis_pkg::PHASE_RESET)
						nxt_st.swrst = 1'b1;
					// no step past the reset vector at cycle end
					if (st_ff.phase == cis_pkg::PHASE_LAST)
						nxt_st.pc = cis_pkg::PC_RST;
				end
				cis_pkg::OPK_NONE:
				begin
					nxt_st.w = st_ff.w;
				end
				default:
				begin
					nxt_st.w = st_ff.w;
				end
			endcase
		end
		// latch the operand while the read strobe stands; data is only valid then
		if (o_mem.rd)
			nxt_st.rdat = i_mem_rdata;
		// the software reset clears program counter and accumulator
		if (st_ff.swrst)
		begin
			nxt_st.pc   = cis_pkg::PC_RST;
			nxt_st.w    = cis_pkg::W_RST;
			nxt_st.idle = 2'h0;
		end
	end

	// state register, frozen while clock enable is low
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st_ff       <= '0;
			st_ff.pc    <= cis_pkg::PC_RST;
			st_ff.w     <= cis_pkg::W_RST;
		end
		else if (i_ce)
			st_ff <= nxt_st;
	end

	// outputs
	assign o_pc                 = st_ff.pc;
	assign o_flush              = st_ff.flush;
	assign o_stall              = (st_ff.idle != 2'h0);
	assign o_wreg               = st_ff.w;
	assign o_carry_we           = st_ff.cwe;
	assign o_carry              = st_ff.cval;
	assign o_master_clear_reset = st_ff.swrst;
	assign o_phase              = st_ff.phase;

endmodule : cis_core

/* test/cis_core_monitor.sv */
/*
 checker for cis_core: addressing, swap, skip, call and reset pulse.
 assumes i_ce stays high across each checked instruction.
*/
`timescale 1ns/1ps
module cis_core_monitor (
	// clock and inputs
	input wire logic              i_sys_clk,
	input wire logic              i_rst,
	input wire logic              i_ce,
	input wire logic [15:0]       i_instr,
	input wire logic              i_ext_set_en,
	input wire logic [3:0]        i_bank_select_register,
	input wire logic [11:0]       i_index_base,
	input wire logic [7:0]        i_mem_rdata,
	// outputs watched
	input wire logic [20:0]       o_pc,
	input wire logic              o_flush,
	input wire logic              o_stall,
	input wire logic              o_carry_we,
	input wire logic [7:0]        o_wreg,
	input wire logic              o_master_clear_reset,
	input wire logic [1:0]        o_phase,
	input wire cis_pkg::cis_mem_s o_mem,
	input wire cis_pkg::cis_stk_s o_stk
);
	logic        swp;   // swap opcode present
	logic [7:0]  sw_ff; // swapped read byte
	logic        lt_ff; // compare outcome
	logic [20:0] tg_ff; // call target
	assign swp = i_instr[15:10] == cis_pkg::OP_SWAP_PFX;
	// capture operands at the phase-1 read or push
	always_ff @(posedge i_sys_clk)
	begin
		if (o_mem.rd)
		begin
			sw_ff <= {i_mem_rdata[3:0], i_mem_rdata[7:4]};
			lt_ff <= i_mem_rdata < o_wreg;
		end
		if (o_stk.push)
			tg_ff <= o_stk.data + {{9{i_instr[10]}}, i_instr[10:0], 1'b0};
	end
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	a_cmp_skip: assert property (
		(o_mem.rd && i_instr[15:9] == cis_pkg::OP_CMP_LT_PFX && i_ce) ##1 i_ce[*2]
		|=> o_flush == lt_ff && o_stall == lt_ff && !o_carry_we) else $error("compare skip wrong");
	a_swap_to_w: assert property (
		(o_mem.rd && swp && !i_instr[9] && i_ce) ##1 i_ce[*2] |=> o_wreg == sw_ff)
		else $error("swap to w wrong");
	a_swap_write: assert property (
		o_mem.wr && swp |-> i_instr[9] && o_phase == 2'h3 && o_mem.wdata == sw_ff)
		else $error("swap write wrong");
	a_push_addr: assert property (
		o_stk.push |-> o_phase == 2'h1 && o_stk.data == o_pc + 21'h2) else $error("push wrong");
	a_call_target: assert property (
		(o_stk.push && i_ce) ##1 i_ce[*2] |=> o_pc == tg_ff && o_flush && o_stall)
		else $error("call target wrong");
	a_bank_addr: assert property (
		o_mem.rd && i_instr[8] |-> o_mem.addr == {i_bank_select_register, i_instr[7:0]})
		else $error("bank address wrong");
	a_indexed_addr: assert property (
		o_mem.rd && swp && i_ext_set_en && !i_instr[8] && i_instr[7:0] <= cis_pkg::ILO_LIMIT
		|-> o_mem.addr == i_index_base + {4'h0, i_instr[7:0]}) else $error("indexed address wrong");
	a_reset_pulse: assert property (
		o_master_clear_reset |-> i_instr == cis_pkg::OP_SWRESET ##1 !o_master_clear_reset)
		else $error("reset pulse wrong");
endmodule : cis_core_monitor
bind cis_core cis_core_monitor u_cis_core_monitor (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_instr(i_instr), .i_ext_set_en(i_ext_set_en),
	.i_bank_select_register(i_bank_select_register), .i_index_base(i_index_base), .i_mem_rdata(i_mem_rdata),
	.o_pc(o_pc), .o_flush(o_flush), .o_stall(o_stall), .o_carry_we(o_carry_we), .o_wreg(o_wreg),
	.o_master_clear_reset(o_master_clear_reset), .o_phase(o_phase), .o_mem(o_mem), .o_stk(o_stk)
);

/* test/cis_mem_model.sv */
/*
 data memory and return stack beside the core.
 assumes reads answer combinationally for the addressed byte.
*/
`timescale 1ns/1ps
module cis_mem_model (
	// clock
	input  wire logic              i_sys_clk,
	input  wire logic              i_ce,
	// requests from the core
	input  wire cis_pkg::cis_mem_s i_mem,
	input  wire cis_pkg::cis_stk_s i_stk,
	// answers
	output logic      [7:0]        o_rdata,
	output logic      [20:0]       o_tos
);
	logic [7:0] mem [4096]; // data memory
	// no read strobe: bus shows inverted data
	assign o_rdata = i_mem.rd ? mem[i_mem.addr] : ~mem[i_mem.addr];
	// write-back and push on enabled edges
	always @(posedge i_sys_clk)
	begin
		if (i_ce && i_mem.wr)
			mem[i_mem.addr] <= i_mem.wdata;
		if (i_ce && i_stk.push)
			o_tos <= i_stk.data;
	end
endmodule : cis_mem_model

/* test/cis_core_tb_top.sv */
/*
 random and corner tests for cis_core.
 assumes the memory model answers reads and stack pushes.
*/
`timescale 1ns/1ps
module cis_core_tb_top;
	logic i_sys_clk, i_rst, i_ce, i_instr_valid, i_next_two_word, i_ext_set_en;
	logic i_carry, i_digit_carry_flag, o_flush, o_stall, o_carry_we, o_carry, o_master_clear_reset, two, lt;
	logic [15:0] i_instr, w;
	logic [3:0]  i_bank_select_register;
	logic [11:0] i_index_base;
	logic [7:0]  i_mem_rdata, o_wreg, v, d;
	logic [20:0] o_pc, return_stack_top, pc0;
	logic [10:0] n;
	logic [1:0]  o_phase;
	cis_pkg::cis_mem_s o_mem;
	cis_pkg::cis_stk_s o_stk;
	int n_fail, checks_done;
	cis_core u_cis_core (
		.i_sys_clk              (i_sys_clk),
		.i_rst                  (i_rst),
		.i_ce                   (i_ce),
		.i_instr                (i_instr),
		.i_instr_valid          (i_instr_valid),
		.i_next_two_word        (i_next_two_word),
		.i_ext_set_en           (i_ext_set_en),
		.i_bank_select_register (i_bank_select_register),
		.i_index_base           (i_index_base),
		.i_mem_rdata            (i_mem_rdata),
		.i_carry                (i_carry),
		.i_digit_carry_flag     (i_digit_carry_flag),
		.o_pc                   (o_pc),
		.o_flush                (o_flush),
		.o_stall                (o_stall),
		.o_mem                  (o_mem),
		.o_stk                  (o_stk),
		.o_wreg                 (o_wreg),
		.o_carry_we             (o_carry_we),
		.o_carry                (o_carry),
		.o_master_clear_reset   (o_master_clear_reset),
		.o_phase                (o_phase)
	);
	cis_mem_model u_cis_mem_model (.i_sys_clk(i_sys_clk), .i_ce(i_ce), .i_mem(o_mem), .i_stk(o_stk),
		.o_rdata(i_mem_rdata), .o_tos(return_stack_top));
	always #2.5 i_sys_clk = ~i_sys_clk;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic put(input logic [11:0] a, input logic [7:0] b);
		u_cis_mem_model.mem[a] = b;
	endtask : put
	// offer a word at phase 0, wait its four phases
	task automatic run(input logic [15:0] iw, input logic tw);
		int k;
		k = 0;
		while (o_phase !== 2'h0 || o_stall !== 1'b0)
		begin
			@(negedge i_sys_clk);
			k++;
			if (k > 40)
			begin
				n_fail++;
				end_of_test();
			end
		end
		pc0 = o_pc;
		i_instr = iw;
		i_next_two_word = tw;
		repeat (4) @(negedge i_sys_clk);
	endtask : run
	// load accumulator by swap into w
	task automatic ldw(input logic [7:0] b);
		put(12'h010, {b[3:0], b[7:4]});
		run(16'h3810, 1'b0);
	endtask : ldw
	function automatic logic [11:0] fa(input logic [15:0] iw);
		if (iw[8])
			return {i_bank_select_register, iw[7:0]};
		if (i_ext_set_en && iw[15:10] == 6'h0e && iw[7:0] <= 8'h5f)
			return i_index_base + {4'h0, iw[7:0]};
		return iw[7:0] < 8'h60 ? {4'h0, iw[7:0]} : {4'hf, iw[7:0]};
	endfunction : fa
	function automatic logic [8:0] decimal_adjust_accumulator(input logic [7:0] b, input logic c, input logic dc);
		logic [8:0] t;
		t = {1'b0, b};
		if (b[3:0] > 4'h9 || dc)
			t = t + 9'h006;
		// a carry out of the low-digit fix also forces the high fix
		if (t[7:4] > 4'h9 || c || t[8])
			t = t + 9'h060;
		return {t[8] | c, t[7:0]};
	endfunction : decimal_adjust_accumulator
	initial
	begin
		{i_sys_clk, i_carry, i_digit_carry_flag, i_next_two_word, i_ext_set_en} = 5'h00;
		{i_rst, i_ce, i_instr_valid} = 3'h7;
		{i_instr, i_bank_select_register, i_index_base} = 32'h0;
		void'($urandom(80216));
		repeat (3) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_rst = 0;
		// swaps over all addressing modes
		for (int i = 0; i < 16; i++)
		begin
			i_ext_set_en = (i < 2) | 1'($urandom);
			i_bank_select_register = 4'($urandom);
			i_index_base = 12'($urandom);
			w = i < 2 ? {8'h38, 8'h5f + 8'(i)} : {6'h0e, 10'($urandom)};
			v = 8'($urandom);
			put(fa(w), v);
			run(w, 1'b0);
			if (w[9])
				chk("file", u_cis_mem_model.mem[fa(w)], {v[3:0], v[7:4]});
			else
				chk("wreg", o_wreg, {v[3:0], v[7:4]});
		end
		$display("swap test done");
		i_ext_set_en = 0;
		for (int i = 0; i < 10; i++)
		begin
			v = 8'($urandom);
			ldw(v);
			w = {8'h61, 8'($urandom)};
			i_bank_select_register = 4'($urandom);
			d = i == 0 ? v : (i == 1 ? v - 8'h01 : 8'($urandom));
			put(fa(w), d);
			two = 1'($urandom);
			run(w, two);
			lt = d < v;
			chk("flush", o_flush, lt);
			chk("pc", o_pc, 21'(pc0 + (lt ? (two ? 21'h6 : 21'h4) : 21'h2)));
			chk("cwe", o_carry_we, 0);
		end
		$display("compare test done");
		for (int i = 0; i < 6; i++)
		begin
			n = i == 0 ? 11'h400 : (i == 1 ? 11'h3ff : 11'($urandom));
			run({5'h1b, n}, 1'b0);
			chk("pc", o_pc, 21'(pc0 + 21'h2 + {{9{n[10]}}, n, 1'b0}));
			chk("tos", return_stack_top, 21'(pc0 + 21'h2));
		end
		$display("call test done");
		for (int i = 0; i < 8; i++)
		begin
			v = i == 0 ? 8'ha5 : (i == 1 ? 8'hce : (i == 2 ? 8'hfa : 8'($urandom)));
			ldw(v);
			i_carry = i > 1 && 1'($urandom);
			i_digit_carry_flag = i > 1 && 1'($urandom);
			run(cis_pkg::OP_DAW, 1'b0);
			chk("daw", {o_carry, o_wreg}, decimal_adjust_accumulator(v, i_carry, i_digit_carry_flag));
			chk("cwe", o_carry_we, 1);
		end
		$display("adjust test done");
		ldw(8'h5a);
		run(cis_pkg::OP_SWRESET, 1'b0);
		chk("rst", {o_pc, o_wreg}, 0);
		$display("reset test done");
		end_of_test();
	end
endmodule : cis_core_tb_top
